// *** src/exec_if.sv ***
// Purpose: carries one instruction request and its result between modules
// Assumes: single clock, request is a one-cycle pulse
// Notes: ctrl drives requests, unit answers one cycle later
`timescale 1ns/1ps
`default_nettype none

interface exec_if
    import vif_pkg::*;
    #(parameter int FLAG_WIDTH = 32);
    logic req_valid;
    instr_op_t op;
    logic gate;
    logic [1:0] io_privilege_level;
    logic virtual_interrupt_pending;
    logic mode_on;
    logic if_in;
    logic vif_in;
    logic [FLAG_WIDTH-1:0] pop_img;
    logic res_valid;
    logic res_if;
    logic res_vif;
    logic res_fault;
    logic res_push;
    logic [FLAG_WIDTH-1:0] push_img;

    modport ctrl
    (
        output req_valid, op, gate, io_privilege_level, virtual_interrupt_pending, mode_on, if_in, vif_in,
        output pop_img,
        input res_valid, res_if, res_vif, res_fault, res_push, push_img
    );
    modport unit
    (
        input req_valid, op, gate, io_privilege_level, virtual_interrupt_pending, mode_on, if_in, vif_in,
        input pop_img,
        output res_valid, res_if, res_vif, res_fault, res_push, push_img
    );
endinterface

`default_nettype wire

// *** src/flag_exec.sv ***
// Purpose: decides the effect of one flag instruction on both flags
// Assumes: request inputs are stable in the cycle of req_valid
// Notes: result registered, valid exactly one cycle after the request
`timescale 1ns/1ps
`include "vif_defs.svh"
`default_nettype none

module flag_exec
    import vif_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    exec_if.unit io
);
    localparam int W = $bits(io.pop_img);

    logic nx_if;
    logic nx_vif;
    logic nx_fault;
    logic nx_push;
    logic [W-1:0] nx_img;
    logic full;

    always_comb
    begin
        full = (io.io_privilege_level == `IO_PRIVILEGE_LEVEL_FULL);
        nx_if = io.if_in;
        nx_vif = io.vif_in;
        nx_fault = 1'b0;
        nx_push = 1'b0;
        // other image bits stay zero: they mean nothing here
        nx_img = '0;
        unique case (io.op)
            OP_CLEAR_IF:
            begin
                if (full || !io.mode_on)
                    nx_if = 1'b0;
                else
                    nx_vif = 1'b0;
            end
            OP_SET_IF:
            begin
                if (full || !io.mode_on)
                    nx_if = 1'b1;
                else if (io.virtual_interrupt_pending)
                    nx_fault = 1'b1;
                else
                    nx_vif = 1'b1;
            end
            OP_PUSH_16:
            begin
                nx_push = 1'b1;
                nx_img[`IMG_IF_POS] = io.if_in;
            end
            OP_PUSH_32:
            begin
                nx_push = 1'b1;
                nx_img[`IMG_IF_POS] = io.if_in;
                // outside the mode the virtual flag is unsupported
                if (io.mode_on)
                    nx_img[`IMG_VIF_POS] = io.vif_in;
            end
            OP_POP_16, OP_INTERRUPT_RETURN_16_16:
                nx_if = io.pop_img[`IMG_IF_POS];
            OP_POP_32:
            begin
                nx_if = io.pop_img[`IMG_IF_POS];
                if (io.mode_on)
                    nx_vif = 1'b0;
            end
            OP_SOFT_INT:
            begin
                nx_push = 1'b1;
                nx_img[`IMG_IF_POS] = io.if_in;
                if (io.gate)
                    nx_if = 1'b0;
            end
            OP_INTERRUPT_RETURN_16_32:
            begin
                nx_if = io.pop_img[`IMG_IF_POS];
                if (io.mode_on)
                    nx_vif = io.pop_img[`IMG_VIF_POS];
            end
            default:
            begin
                nx_if = io.if_in;
            end
        endcase
        // a fault leaves both flags as they were
        if (nx_fault)
        begin
            nx_if = io.if_in;
            nx_vif = io.vif_in;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            io.res_valid <= 1'b0;
        else
            io.res_valid <= io.req_valid;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            io.res_if <= 1'b0;
            io.res_vif <= 1'b0;
            io.res_fault <= 1'b0;
            io.res_push <= 1'b0;
            io.push_img <= '0;
        end
        else if (io.req_valid)
        begin
            io.res_if <= nx_if;
            io.res_vif <= nx_vif;
            io.res_fault <= nx_fault;
            io.res_push <= nx_push;
            io.push_img <= nx_img;
        end
    end

endmodule

`default_nettype wire

// *** src/vif_ctrl_top.sv ***
// Purpose: interrupt flag and virtual interrupt flag control, AHB-Lite regs
// Assumes: single 100 MHz clock, one AHB-Lite master, word transfers only
// Notes: reads take one wait state; a command stalls the bus until applied unless a read is taken in its data phase
`timescale 1ns/1ps
`include "vif_defs.svh"
`default_nettype none

// Operation
// - 16-bit flag push in the mode stores the interrupt flag only.
// - 32-bit flag push in the mode also stores the virtual flag.
// - 16-bit pop and return load the interrupt flag, virtual flag kept.
// - 32-bit return in the mode loads the virtual flag from the image.
// - software interrupt pushes the flag, clears it only through a gate.
// - flag bits unsupported in the current mode are ignored.
// - set below level 3 in the mode with pending virtual interrupt faults, no change.
module vif_ctrl_top
    import vif_pkg::*;
#(
    parameter int FLAG_WIDTH = 32
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    output logic interrupt_enable_flag,
    output logic virtual_interrupt_flag,
    output logic general_protection_fault
);
    generate
        if (FLAG_WIDTH != 32)
        begin : g_bad_width
            $error("flag image must be one 32-bit bus word");
        end
    endgenerate

    exec_if #(.FLAG_WIDTH(FLAG_WIDTH)) xio ();

    flag_exec u_exec
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .io(xio)
    );

    // bus transfer state
    logic addr_take;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [7:0] rd_addr_reg;
    logic word_ok;

    // software visible state
    logic [4:0] ctrl_reg;
    logic [4:0] cmd_reg;
    logic [FLAG_WIDTH-1:0] pop_img_reg;
    logic [FLAG_WIDTH-1:0] push_img_reg;
    logic [`ST_WIDTH-1:0] status_reg;
    logic [`ST_WIDTH-1:0] status_next;
    logic [`ST_WIDTH-1:0] mask_reg;
    logic if_reg;
    logic vif_reg;
    logic req_reg;

    logic wr_ctrl;
    logic wr_flags;
    logic wr_cmd;
    logic wr_pop;
    logic wr_status;
    logic wr_mask;
    logic [31:0] rd_mux;
    logic [`ST_WIDTH-1:0] events;
    logic mode_on;

    // only whole-word writes carry a register; other writes are ignored, reads of any size return one
    assign word_ok = (hsize == 3'h2);
    assign addr_take = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rd_addr_reg <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= addr_take && hwrite && word_ok;
            rd_pend_reg <= addr_take && !hwrite;
            if (addr_take)
            begin
                wr_addr_reg <= haddr[7:0];
                rd_addr_reg <= haddr[7:0];
            end
        end
    end

    // addresses above the window are unmapped
    always_comb
    begin
        wr_ctrl = 1'b0;
        wr_flags = 1'b0;
        wr_cmd = 1'b0;
        wr_pop = 1'b0;
        wr_status = 1'b0;
        wr_mask = 1'b0;
        if (wr_pend_reg)
        begin
            unique case (wr_addr_reg)
                `OFS_CTRL: wr_ctrl = 1'b1;
                `OFS_FLAGS: wr_flags = 1'b1;
                `OFS_CMD: wr_cmd = 1'b1;
                `OFS_POP_IMAGE: wr_pop = 1'b1;
                `OFS_STATUS: wr_status = 1'b1;
                `OFS_MASK: wr_mask = 1'b1;
                default: wr_ctrl = 1'b0;
            endcase
        end
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (rd_addr_reg)
            `OFS_CTRL: rd_mux[4:0] = ctrl_reg;
            `OFS_FLAGS:
            begin
                rd_mux[`FLAGS_IF_BIT] = if_reg;
                rd_mux[`FLAGS_VIF_BIT] = vif_reg;
            end
            `OFS_CMD: rd_mux[4:0] = cmd_reg;
            `OFS_POP_IMAGE: rd_mux = pop_img_reg;
            `OFS_PUSH_IMAGE: rd_mux = push_img_reg;
            `OFS_STATUS: rd_mux[`ST_WIDTH-1:0] = status_reg;
            `OFS_MASK: rd_mux[`ST_WIDTH-1:0] = mask_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data is loaded in the first data cycle, so a write just ahead
    // of it is already visible
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (rd_pend_reg)
            hrdata <= rd_mux;
    end

    // low for a read's first data cycle, and from a command write
    // until its result is applied; a read taken in the write's data phase ends it a cycle early and sees the old flags
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hreadyout <= 1'b1;
        else if (addr_take && !hwrite)
            hreadyout <= 1'b0;
        else if (wr_cmd)
            hreadyout <= 1'b0;
        else if (rd_pend_reg || xio.res_valid)
            hreadyout <= 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hresp <= 1'b0;
        else
            hresp <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_reg <= `CTRL_RESET;
        else if (wr_ctrl)
            ctrl_reg <= hwdata[4:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pop_img_reg <= `IMAGE_RESET;
        else if (wr_pop)
            pop_img_reg <= hwdata[FLAG_WIDTH-1:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mask_reg <= `MASK_RESET;
        else if (wr_mask)
            mask_reg <= hwdata[`ST_WIDTH-1:0];
    end

    // a command write launches one instruction
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmd_reg <= `CMD_RESET;
            req_reg <= 1'b0;
        end
        else
        begin
            req_reg <= wr_cmd;
            if (wr_cmd)
                cmd_reg <= hwdata[4:0];
        end
    end

    assign mode_on = ctrl_reg[`CTRL_PVI_BIT] && ctrl_reg[`CTRL_CPL3_BIT];

    assign xio.req_valid = req_reg;
    assign xio.op = instr_op_t'(cmd_reg[`CMD_OP_HI:`CMD_OP_LO]);
    assign xio.gate = cmd_reg[`CMD_GATE_BIT];
    assign xio.io_privilege_level = ctrl_reg[`CTRL_IO_PRIVILEGE_LEVEL_HI:`CTRL_IO_PRIVILEGE_LEVEL_LO];
    assign xio.virtual_interrupt_pending = ctrl_reg[`CTRL_VIP_BIT];
    assign xio.mode_on = mode_on;
    assign xio.if_in = if_reg;
    assign xio.vif_in = vif_reg;
    assign xio.pop_img = pop_img_reg;

    // the bus is stalled in the cycle before a result lands, so a software write
    // of the flags can never meet one in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            if_reg <= 1'b0;
            vif_reg <= 1'b0;
        end
        else if (xio.res_valid)
        begin
            if_reg <= xio.res_if;
            vif_reg <= xio.res_vif;
        end
        else if (wr_flags)
        begin
            if_reg <= hwdata[`FLAGS_IF_BIT];
            vif_reg <= hwdata[`FLAGS_VIF_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            push_img_reg <= `IMAGE_RESET;
        else if (xio.res_valid && xio.res_push)
            push_img_reg <= xio.push_img;
    end

    always_comb
    begin
        events = '0;
        events[`ST_DONE_BIT] = xio.res_valid;
        events[`ST_FAULT_BIT] = xio.res_valid && xio.res_fault;
        events[`ST_PUSH_BIT] = xio.res_valid && xio.res_push;
    end

    // write-one-to-clear, a new event in the same cycle wins
    always_comb
    begin
        status_next = status_reg;
        if (wr_status)
            status_next = status_next & ~hwdata[`ST_WIDTH-1:0];
        status_next = status_next | events;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            status_reg <= `ST_RESET;
        else
            status_reg <= status_next;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq <= 1'b0;
        else
            irq <= |(status_next & mask_reg);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            general_protection_fault <= 1'b0;
        else
            general_protection_fault <= events[`ST_FAULT_BIT];
    end

    // flag outputs mirror the state one cycle behind
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            interrupt_enable_flag <= 1'b0;
            virtual_interrupt_flag <= 1'b0;
        end
        else
        begin
            interrupt_enable_flag <= if_reg;
            virtual_interrupt_flag <= vif_reg;
        end
    end

endmodule

`default_nettype wire

// *** src/vif_defs.svh ***
// Purpose: offsets, field positions, reset values of the flag control block
// Assumes: 32-bit register words on an AHB-Lite slave, byte addresses
// Notes: definitions only
`ifndef VIF_DEFS_SVH
`define VIF_DEFS_SVH

`define OFS_CTRL 8'h00
`define OFS_FLAGS 8'h04
`define OFS_CMD 8'h08
`define OFS_POP_IMAGE 8'h0C
`define OFS_PUSH_IMAGE 8'h10
`define OFS_STATUS 8'h14
`define OFS_MASK 8'h18

// control register fields
`define CTRL_IO_PRIVILEGE_LEVEL_LO 0
`define CTRL_IO_PRIVILEGE_LEVEL_HI 1
`define CTRL_VIP_BIT 2
`define CTRL_PVI_BIT 3
`define CTRL_CPL3_BIT 4

// flags register fields
`define FLAGS_IF_BIT 0
`define FLAGS_VIF_BIT 1

// command register fields
`define CMD_OP_LO 0
`define CMD_OP_HI 3
`define CMD_GATE_BIT 4

// status and mask fields
`define ST_DONE_BIT 0
`define ST_FAULT_BIT 1
`define ST_PUSH_BIT 2
`define ST_WIDTH 3

// bit positions inside a flags image on the stack
`define IMG_IF_POS 9
`define IMG_VIF_POS 19

// reset values
`define CTRL_RESET 5'h00
`define FLAGS_RESET 2'h0
`define CMD_RESET 5'h00
`define IMAGE_RESET 32'h0000_0000
`define ST_RESET 3'h0
`define MASK_RESET 3'h0

// privilege level that grants direct control of the interrupt flag
`define IO_PRIVILEGE_LEVEL_FULL 2'h3

`endif

// *** src/vif_pkg.sv ***
// Purpose: types shared by the flag control block
// Assumes: nothing beyond the definitions header
// Notes: opcode values are the ones software writes into the command word
package vif_pkg;

    typedef enum logic [3:0]
    {
        OP_CLEAR_IF = 4'h0,
        OP_SET_IF = 4'h1,
        OP_PUSH_16 = 4'h2,
        OP_PUSH_32 = 4'h3,
        OP_POP_16 = 4'h4,
        OP_POP_32 = 4'h5,
        OP_SOFT_INT = 4'h6,
        OP_INTERRUPT_RETURN_16_16 = 4'h7,
        OP_INTERRUPT_RETURN_16_32 = 4'h8
    } instr_op_t;

endpackage

// *** tb/tb_vif_ctrl_top.sv ***
// Purpose: register-level test of vif_ctrl_top over AHB-Lite
// Assumes: one master, hready looped from hreadyout
// Notes: each case sets mode and flags, then launches one instruction
`timescale 1ns/1ps
`include "vif_defs.svh"
`default_nettype none

module tb_vif_ctrl_top
    import vif_pkg::*;
;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic irq;
    logic ie_flag;
    logic vi_flag;
    logic gp_fault;
    logic [31:0] rd;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    int n_faults = 0;

    vif_ctrl_top i_vif_ctrl_top
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .irq(irq),
        .interrupt_enable_flag(ie_flag),
        .virtual_interrupt_flag(vi_flag),
        .general_protection_fault(gp_fault)
    );

    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // guards against a hung handshake, a full run is under 2000 cycles
    // the fault output is a one-cycle pulse, so it is counted as it passes
    always @(posedge hclk)
    begin
        cycles++;
        if (gp_fault === 1'b1)
            n_faults++;
        if (cycles == 20000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rdata);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdata = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, rd);
        cmp(rd, exp);
    endtask

    task automatic irq_is(input logic exp);
        repeat (2) @(posedge hclk);
        cmp({31'h0, irq}, {31'h0, exp});
    endtask

    // img, ep: {bit 19, bit 9} of a stack image; ef: {vif, if}
    task automatic chk(input logic [4:0] ctl, input logic [1:0] fl,
        input instr_op_t op, input logic g, input logic [1:0] img,
        input logic [1:0] ef, input logic [1:0] ep, input logic flt);
        int f0;
        f0 = n_faults;
        wr(`OFS_STATUS, 32'h0000_0007);
        wr(`OFS_CTRL, {27'h0, ctl});
        wr(`OFS_FLAGS, {30'h0, fl});
        wr(`OFS_POP_IMAGE, {12'h0, img[1], 9'h0, img[0], 9'h000});
        wr(`OFS_CMD, {27'h0, g, op});
        rdc(`OFS_FLAGS, {30'h0, ef});
        if (op inside {OP_PUSH_16, OP_PUSH_32, OP_SOFT_INT})
            rdc(`OFS_PUSH_IMAGE, {12'h0, ep[1], 9'h0, ep[0], 9'h000});
        bus(1'b0, `OFS_STATUS, 32'h0, rd);
        cmp({30'h0, rd[1:0]}, {30'h0, flt, 1'b1});
        cmp(32'(n_faults - f0), {31'h0, flt});
        cmp({30'h0, vi_flag, ie_flag}, {30'h0, ef});
        cmp({31'h0, irq}, {31'h0, flt});
    endtask

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        cmp({28'h0, irq, ie_flag, vi_flag, gp_fault}, 32'h0);
        // offset 0x1C is unmapped and must read zero as well
        for (int i = 0; i < 8; i++)
            rdc(8'(i * 4), 32'h0);
        wr(8'h1C, 32'hFFFF_FFFF);
        rdc(8'h1C, 32'h0);
        wr(`OFS_CTRL, 32'hFFFF_FFFF);
        rdc(`OFS_CTRL, 32'h0000_001F);
        wr(`OFS_MASK, 32'h0000_0002);
        rdc(`OFS_MASK, 32'h0000_0002);
        chk(5'h1B, 2'h3, OP_CLEAR_IF, 1'b0, 2'h0, 2'h2, 2'h0, 1'b0);
        chk(5'h1B, 2'h0, OP_SET_IF, 1'b0, 2'h0, 2'h1, 2'h0, 1'b0);
        chk(5'h18, 2'h3, OP_CLEAR_IF, 1'b0, 2'h0, 2'h1, 2'h0, 1'b0);
        chk(5'h18, 2'h0, OP_SET_IF, 1'b0, 2'h0, 2'h2, 2'h0, 1'b0);
        chk(5'h1F, 2'h0, OP_SET_IF, 1'b0, 2'h0, 2'h1, 2'h0, 1'b0);
        chk(5'h1E, 2'h0, OP_SET_IF, 1'b0, 2'h0, 2'h0, 2'h0, 1'b1);
        wr(`OFS_MASK, 32'h0);
        irq_is(1'b0);
        wr(`OFS_MASK, 32'h0000_0002);
        irq_is(1'b1);
        wr(`OFS_STATUS, 32'h0000_0002);
        irq_is(1'b0);
        rdc(`OFS_STATUS, 32'h0000_0001);
        chk(5'h1B, 2'h3, OP_PUSH_16, 1'b0, 2'h0, 2'h3, 2'h1, 1'b0);
        chk(5'h18, 2'h2, OP_PUSH_32, 1'b0, 2'h0, 2'h2, 2'h2, 1'b0);
        chk(5'h1B, 2'h2, OP_POP_16, 1'b0, 2'h1, 2'h3, 2'h0, 1'b0);
        chk(5'h18, 2'h0, OP_POP_16, 1'b0, 2'h3, 2'h1, 2'h0, 1'b0);
        chk(5'h1B, 2'h3, OP_INTERRUPT_RETURN_16_16, 1'b0, 2'h2, 2'h2, 2'h0, 1'b0);
        chk(5'h1B, 2'h1, OP_INTERRUPT_RETURN_16_32, 1'b0, 2'h2, 2'h2, 2'h0, 1'b0);
        chk(5'h1B, 2'h3, OP_SOFT_INT, 1'b1, 2'h0, 2'h2, 2'h1, 1'b0);
        chk(5'h18, 2'h1, OP_SOFT_INT, 1'b0, 2'h0, 2'h1, 2'h1, 1'b0);
        chk(5'h08, 2'h3, OP_PUSH_32, 1'b0, 2'h0, 2'h3, 2'h1, 1'b0);
        chk(5'h08, 2'h0, OP_INTERRUPT_RETURN_16_32, 1'b0, 2'h3, 2'h1, 2'h0, 1'b0);
        chk(5'h14, 2'h0, OP_SET_IF, 1'b0, 2'h0, 2'h1, 2'h0, 1'b0);
        chk(5'h1B, 2'h3, OP_POP_32, 1'b0, 2'h1, 2'h1, 2'h0, 1'b0);
        // an undefined opcode leaves both flags and only reports done
        chk(5'h1B, 2'h3, instr_op_t'(4'hF), 1'b0, 2'h0, 2'h3, 2'h0, 1'b0);
        report_and_stop();
    end
endmodule

`default_nettype wire

// *** tb/vif_ctrl_top_properties.sv ***
// Purpose: bus timing and flag output checks for vif_ctrl_top
// Assumes: sees only the top module's ports, hready looped back
// Notes: ages count cycles since a write, to tie changes to a cause
`timescale 1ns/1ps
`default_nettype none

module vif_ctrl_top_properties
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic irq,
    input wire logic interrupt_enable_flag,
    input wire logic virtual_interrupt_flag,
    input wire logic general_protection_fault
);
    logic taken;
    logic rd_taken;
    logic cmd_taken;
    logic [3:0] wr_age;
    logic [3:0] cmd_age;

    assign taken = hsel && htrans[1] && hready;
    assign rd_taken = taken && !hwrite;
    assign cmd_taken = taken && hwrite && hsize == 3'h2
        && haddr[7:0] == 8'h08;

    // ages saturate so an idle stretch never wraps back to "recent"
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_age <= 4'hF;
            cmd_age <= 4'hF;
        end
        else
        begin
            if (taken && hwrite)
                wr_age <= 4'h0;
            else if (wr_age != 4'hF)
                wr_age <= wr_age + 4'h1;
            if (cmd_taken)
                cmd_age <= 4'h0;
            else if (cmd_age != 4'hF)
                cmd_age <= cmd_age + 4'h1;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_resp_okay;
        hresp == 1'b0;
    endproperty
    a_resp_okay: assert property (p_resp_okay)
        else $error("slave response not okay");

    property p_read_wait;
        rd_taken |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read wait state wrong");

    property p_write_nowait;
        taken && hwrite && haddr[7:0] != 8'h08 |=> hreadyout;
    endproperty
    a_write_nowait: assert property (p_write_nowait)
        else $error("register write stalled");

    property p_cmd_stall;
        cmd_taken |=> hreadyout ##1 !hreadyout [*2] ##1 hreadyout;
    endproperty
    a_cmd_stall: assert property (p_cmd_stall)
        else $error("command stall length wrong");

    property p_hrdata_hold;
        $changed(hrdata) |-> $past(rd_taken, 2);
    endproperty
    a_hrdata_hold: assert property (p_hrdata_hold)
        else $error("read data changed without a read");

    property p_fault_pulse;
        general_protection_fault |=> !general_protection_fault;
    endproperty
    a_fault_pulse: assert property (p_fault_pulse)
        else $error("fault longer than one cycle");

    property p_fault_cause;
        general_protection_fault |-> cmd_age inside {[4'h1:4'h5]};
    endproperty
    a_fault_cause: assert property (p_fault_cause)
        else $error("fault without a command");

    property p_flags_quiet;
        $changed({interrupt_enable_flag, virtual_interrupt_flag})
            |-> wr_age <= 4'h8;
    endproperty
    a_flags_quiet: assert property (p_flags_quiet)
        else $error("flag changed with no write");

    property p_irq_quiet;
        $changed(irq) |-> wr_age <= 4'h8;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("irq changed with no write");

    c_read: cover property (rd_taken);
    c_cmd: cover property (cmd_taken);
    c_fault: cover property (general_protection_fault);
    c_irq: cover property ($rose(irq));
endmodule

bind vif_ctrl_top vif_ctrl_top_properties i_vif_ctrl_top_properties
(
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .irq, .interrupt_enable_flag,
    .virtual_interrupt_flag, .general_protection_fault
);

`default_nettype wire
